// File: fsp_defs.svh
// constants for the flash self-programming control block
// assumes an 8-bit peripheral space at ff00h-ffffh and a 125 MHz cpu clock
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// register byte addresses
`define FSP_PROT_CMD_ADDR 16'hffa0
`define FSP_STATUS_ADDR 16'hffa1
`define FSP_MODE_CTRL_ADDR 16'hffa2
`define FSP_FLASH_CMD_ADDR 16'hffa3
`define FSP_PERIPH_PAGE 8'hff
// unlock key and data values
`define FSP_UNLOCK_KEY 8'ha5
`define FSP_BLANK_BYTE 8'hff
`define FSP_ZERO_BYTE 8'h00
// protect byte location and the lsb of its five setting bits
`define FSP_PROT_BYTE_ADDR 16'h0081
`define FSP_PBYTE_LSB 0
// mode control field positions
`define FSP_MODE_BIT 0
`define FSP_PROT_LSB 2
`define FSP_PROT_MSB 6
// status field positions
`define FSP_ST_SEQ_ERR 0
`define FSP_ST_VERIFY_ERR 1
`define FSP_ST_PROT_ERR 2
// flash command codes
`define FSP_CMD_NONE 3'h0
`define FSP_CMD_ERASE 3'h3
// entry halt release time: 10 us plus 2 cpu clocks, counted in whole cpu clocks
`define FSP_ENTRY_US 10
`define FSP_CLK_MHZ 125
`define FSP_ENTRY_EXTRA 2
`define FSP_ENTRY_CYC (`FSP_ENTRY_US * `FSP_CLK_MHZ + `FSP_ENTRY_EXTRA)
`endif

// File: fsp_pkg.sv
// types for the flash self-programming control block
// assumes fsp_defs.svh is compiled alongside
package fsp_pkg;
  typedef enum logic [2:0] {S_LOAD, S_LOADW, S_RUN, S_ENTRY, S_BUSY, S_STANDBY} fsp_state_t;
  typedef enum logic [1:0] {Q_IDLE, Q_KEY, Q_VAL, Q_INV} fsp_seq_t;
  typedef logic [2:0] fsp_cmd_t;
endpackage

// File: fsp_seq_if.sv
// carrier between the control top and its unlock sequencer
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface fsp_seq_if;
  logic wr_key;
  logic wr_mode;
  logic wr_other;
  logic [7:0] wdata;
  logic commit;
  logic commit_val;
  logic err_set;
  modport ctrl (output wr_key, output wr_mode, output wr_other, output wdata,
    input commit, input commit_val, input err_set);
  modport seq (input wr_key, input wr_mode, input wr_other, input wdata,
    output commit, output commit_val, output err_set);
endinterface

// File: fsp_unlock_seq.sv
// protected write sequencer for the mode control register
// assumes each peripheral store arrives as a one-cycle strobe on the carrier
`timescale 1ns/10ps
`include "fsp_defs.svh"
module fsp_unlock_seq
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  fsp_seq_if.seq sq
);
  fsp_seq_t seq;
  fsp_seq_t next_seq;
  logic [7:0] held;
  logic any_wr;
  logic key_ok;
  logic inv_ok;
  logic val_ok;
  logic brk;

  // step checks; any store that does not continue the chain breaks it, except a store to another register while idle
  assign any_wr = sq.wr_key | sq.wr_mode | sq.wr_other;
  assign key_ok = sq.wr_key && (sq.wdata == `FSP_UNLOCK_KEY);
  assign inv_ok = sq.wr_mode && (sq.wdata == ~held);
  assign val_ok = sq.wr_mode && (sq.wdata == held);
  assign brk = any_wr && ((seq == Q_IDLE && !key_ok && !sq.wr_other)
    || (seq == Q_KEY && !sq.wr_mode)
    || (seq == Q_VAL && !inv_ok)
    || (seq == Q_INV && !val_ok));

  // next step of the chain
  always_comb
  begin
    next_seq = seq;
    unique case (seq)
      Q_IDLE: if (key_ok) next_seq = Q_KEY;
      Q_KEY: if (any_wr) next_seq = sq.wr_mode ? Q_VAL : Q_IDLE;
      Q_VAL: if (any_wr) next_seq = inv_ok ? Q_INV : Q_IDLE;
      Q_INV: if (any_wr) next_seq = Q_IDLE;
    endcase
  end

  // only the fourth store of an unbroken chain commits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      seq <= Q_IDLE;
      held <= 8'h00;
      sq.commit <= 1'b0;
      sq.commit_val <= 1'b0;
      sq.err_set <= 1'b0;
    end
    else
    begin
      seq <= next_seq;
      if (seq == Q_KEY && sq.wr_mode)
        held <= sq.wdata;
      sq.commit <= (seq == Q_INV) && val_ok;
      sq.commit_val <= sq.wdata[`FSP_MODE_BIT];
      sq.err_set <= brk;
    end
  end

  a_commit_only_chain: assert property (@(posedge clk) disable iff (!rst_n)
    sq.commit |-> $past(seq) == Q_INV && $past(sq.wr_mode))
    else $error("mode commit without a full chain");
  a_commit_value: assert property (@(posedge clk) disable iff (!rst_n)
    (seq == Q_INV && val_ok) |=> sq.commit && sq.commit_val == $past(held[0]))
    else $error("valid final store did not commit");
  a_break_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (seq == Q_VAL && sq.wr_mode && !inv_ok) |=> sq.err_set && !sq.commit && seq == Q_IDLE)
    else $error("broken chain not flagged");
endmodule

// File: fsp_ctrl.sv
// flash self-programming control: mode select, halt launch, protect readback
// assumes a cpu halt strobe, a flash macro with done/error strobes, sync reset
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "fsp_defs.svh"
// How it works
// - stall cpu until flash command completes
// - hold interrupts until self-programming mode ends
// - no ram access during a command
// - block erase writes blank ffh everywhere
// - entry halt released within 10us plus 2
// - pins held as in halt standby
// - ignore external security in self-programming
// - protection taken from protect byte 0081h
// - mode register written only by unlock sequence
// - halt is standby or flash launch
// - reset clears mode, loads protect bits
// - protect bits read-only, bits 7,1 zero
// - key, value, inverse, value; last counts
// - broken sequence sets sticky error flag
module fsp_ctrl
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cpu_halt,
  input wire logic wake_req,
  output logic cpu_stall,
  output logic halt_release,
  output logic standby,
  output logic irq_enable,
  output logic pin_hold,
  output logic ram_block,
  output logic sec_override,
  output logic flash_start,
  output logic [2:0] flash_cmd,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_wr_buf,
  input wire logic flash_done,
  input wire logic flash_verify_err,
  input wire logic flash_protect_err,
  output logic flash_rd,
  output logic [15:0] flash_addr,
  input wire logic [7:0] flash_rdata
);
  localparam int ENTRY_LIM = `FSP_ENTRY_CYC;
  localparam logic [11:0] ENTRY_LAST = 12'(ENTRY_LIM - 1);

  fsp_seq_if sq ();

  fsp_state_t state;
  fsp_state_t next_state;
  logic mode_sel;
  logic entry_pend;
  logic [4:0] prot_bits;
  logic seq_err;
  logic verify_err;
  logic prot_err;
  fsp_cmd_t cmd_reg;
  logic [11:0] entry_cnt;
  logic rd_q;

  // address decode
  logic periph;
  logic hit_key;
  logic hit_status;
  logic hit_mode;
  logic hit_cmd;
  assign periph = reg_addr[15:8] == `FSP_PERIPH_PAGE;
  assign hit_key = reg_addr == `FSP_PROT_CMD_ADDR;
  assign hit_status = reg_addr == `FSP_STATUS_ADDR;
  assign hit_mode = reg_addr == `FSP_MODE_CTRL_ADDR;
  assign hit_cmd = reg_addr == `FSP_FLASH_CMD_ADDR;

  // every peripheral store is shown to the sequencer
  assign sq.wr_key = reg_wr && hit_key;
  assign sq.wr_mode = reg_wr && hit_mode;
  assign sq.wr_other = reg_wr && periph && !hit_key && !hit_mode;
  assign sq.wdata = reg_wdata;

  fsp_unlock_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .sq(sq)
  );

  // read views; reserved bits and the write-only key register read zero
  logic [7:0] mode_view;
  logic [7:0] status_view;
  logic [7:0] rd_mux;
  assign mode_view = {1'b0, prot_bits, 1'b0, mode_sel};
  assign status_view = {5'h00, prot_err, verify_err, seq_err};
  assign rd_mux = hit_mode ? mode_view :
    hit_status ? status_view :
    hit_cmd ? {5'h00, cmd_reg} : `FSP_ZERO_BYTE;

  // halt decode
  logic halt_take;
  logic go_standby;
  logic go_entry;
  logic go_busy;
  logic go_quick;
  logic entry_done;
  logic is_erase;
  assign halt_take = cpu_halt && (state == S_RUN);
  assign go_standby = halt_take && !mode_sel;
  assign go_entry = halt_take && mode_sel && entry_pend;
  assign go_busy = halt_take && mode_sel && !entry_pend && (cmd_reg != `FSP_CMD_NONE);
  assign go_quick = halt_take && mode_sel && !entry_pend && (cmd_reg == `FSP_CMD_NONE);
  assign entry_done = (state == S_ENTRY) && (entry_cnt == ENTRY_LAST);
  assign is_erase = cmd_reg == `FSP_CMD_ERASE;

  // main sequence
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_LOAD: next_state = S_LOADW;
      S_LOADW: next_state = S_RUN;
      S_RUN:
      begin
        if (go_standby)
          next_state = S_STANDBY;
        else if (go_entry)
          next_state = S_ENTRY;
        else if (go_busy)
          next_state = S_BUSY;
      end
      S_ENTRY: if (entry_done) next_state = S_RUN;
      S_BUSY: if (flash_done) next_state = S_RUN;
      S_STANDBY: if (wake_req) next_state = S_RUN;
    endcase
  end

  // sequencer state and entry timer; sync reset also aborts a running command
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= S_LOAD;
      entry_cnt <= 12'h000;
    end
    else
    begin
      state <= next_state;
      entry_cnt <= (state == S_ENTRY) ? entry_cnt + 12'h001 : 12'h000;
    end
  end

  // mode select, entry marker and protect bits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_sel <= 1'b0;
      entry_pend <= 1'b0;
      prot_bits <= 5'h00;
    end
    else
    begin
      if (sq.commit && state == S_RUN)
      begin
        mode_sel <= sq.commit_val;
        entry_pend <= sq.commit_val;
      end
      else if (go_entry)
        entry_pend <= 1'b0;
      if (state == S_LOADW)
        prot_bits <= flash_rdata[`FSP_PBYTE_LSB +: 5];
    end
  end

  // protect byte fetch right after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flash_rd <= 1'b0;
      flash_addr <= 16'h0000;
    end
    else
    begin
      flash_rd <= state == S_LOAD;
      flash_addr <= (state == S_LOAD) ? `FSP_PROT_BYTE_ADDR : 16'h0000;
    end
  end

  // command register and status flags; a set in the clear cycle wins
  logic st_clr0;
  logic st_clr1;
  logic st_clr2;
  assign st_clr0 = reg_wr && hit_status && !reg_wdata[`FSP_ST_SEQ_ERR];
  assign st_clr1 = reg_wr && hit_status && !reg_wdata[`FSP_ST_VERIFY_ERR];
  assign st_clr2 = reg_wr && hit_status && !reg_wdata[`FSP_ST_PROT_ERR];
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmd_reg <= `FSP_CMD_NONE;
      seq_err <= 1'b0;
      verify_err <= 1'b0;
      prot_err <= 1'b0;
    end
    else
    begin
      if (reg_wr && hit_cmd)
        cmd_reg <= reg_wdata[2:0];
      seq_err <= sq.err_set | (seq_err & !st_clr0);
      verify_err <= (state == S_BUSY && flash_done && flash_verify_err)
        | (verify_err & !st_clr1);
      prot_err <= (state == S_BUSY && flash_done && flash_protect_err)
        | (prot_err & !st_clr2);
    end
  end

  // flash launch; erase fills the block with the blank byte
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flash_start <= 1'b0;
      flash_cmd <= `FSP_CMD_NONE;
      flash_wdata <= `FSP_ZERO_BYTE;
    end
    else
    begin
      flash_start <= go_busy;
      if (go_busy)
      begin
        flash_cmd <= cmd_reg;
        flash_wdata <= is_erase ? `FSP_BLANK_BYTE : flash_wr_buf;
      end
    end
  end

  // cpu-facing levels follow the next state so they line up with it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cpu_stall <= 1'b0;
      ram_block <= 1'b0;
      standby <= 1'b0;
      halt_release <= 1'b0;
    end
    else
    begin
      cpu_stall <= next_state == S_BUSY || next_state == S_ENTRY;
      ram_block <= next_state == S_BUSY;
      standby <= next_state == S_STANDBY;
      halt_release <= entry_done || go_quick || (state == S_BUSY && flash_done)
        || (state == S_STANDBY && wake_req);
    end
  end

  // mode-wide side effects lag the mode bit by one clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_enable <= 1'b0;
      pin_hold <= 1'b0;
      sec_override <= 1'b0;
    end
    else
    begin
      irq_enable <= !mode_sel && state != S_LOAD && state != S_LOADW;
      pin_hold <= mode_sel;
      sec_override <= mode_sel;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      rd_q <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      rd_q <= reg_rd && hit_mode;
    end
  end

  a_stall_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_BUSY) |-> cpu_stall && !halt_release)
    else $error("cpu not stalled during flash command");
  a_irq_held: assert property (@(posedge clk) disable iff (!rst_n)
    mode_sel |=> !irq_enable)
    else $error("interrupts enabled in self-programming mode");
  a_ram_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_BUSY) |-> ram_block)
    else $error("ram not blocked during command");
  a_erase_blank: assert property (@(posedge clk) disable iff (!rst_n)
    (flash_start && flash_cmd == `FSP_CMD_ERASE) |-> flash_wdata == `FSP_BLANK_BYTE)
    else $error("erase data is not blank");
  a_entry_bound: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_ENTRY) |-> entry_cnt < 12'(ENTRY_LIM))
    else $error("entry halt held too long");
  a_entry_release: assert property (@(posedge clk) disable iff (!rst_n)
    entry_done |=> halt_release && state == S_RUN && !cpu_stall)
    else $error("entry halt not released");
  a_pins_held: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_sel && $past(mode_sel)) |-> pin_hold && sec_override)
    else $error("pins or security not in self-programming state");
  a_prot_fetch: assert property (@(posedge clk) disable iff (!rst_n)
    flash_rd |-> flash_addr == `FSP_PROT_BYTE_ADDR ##1 state == S_RUN)
    else $error("protect byte fetched from wrong address");
  a_halt_split: assert property (@(posedge clk) disable iff (!rst_n)
    (halt_take && !mode_sel) |=> standby && !flash_start)
    else $error("normal halt did not enter standby");
  a_mode_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    (state == S_LOAD || state == S_LOADW) |-> !mode_sel)
    else $error("mode bit set during protect load");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd_q |-> !reg_rdata[7] && !reg_rdata[1])
    else $error("reserved mode bits read nonzero");
  a_mode_guard: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(mode_sel) && state != S_LOADW) |-> $past(sq.commit))
    else $error("mode bit changed without unlock");
endmodule

// File: fsp_flash_model.sv
// flash macro model facing the self-programming control block
// assumes launch and protect-byte reads come from the block on clk
`timescale 1ns/10ps
module fsp_flash_model
#(
  parameter int DONE_DLY = 20,
  parameter logic [7:0] PROT_BYTE = 8'hf5
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flash_rd,
  input wire logic [15:0] flash_addr,
  input wire logic flash_start,
  input wire logic verr_in,
  input wire logic perr_in,
  output logic [7:0] flash_rdata,
  output logic flash_done,
  output logic flash_verify_err,
  output logic flash_protect_err
);
  int cnt;
  // inverted data outside the read, so a late sample never matches by luck
  assign flash_rdata = (flash_rd && flash_addr == 16'h0081) ? PROT_BYTE : ~PROT_BYTE;
  // done pulse a fixed time after launch; errors only beside done
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      flash_done <= 1'b0;
      flash_verify_err <= 1'b0;
      flash_protect_err <= 1'b0;
    end
    else
    begin
      flash_done <= (cnt == 1);
      flash_verify_err <= (cnt == 1) && verr_in;
      flash_protect_err <= (cnt == 1) && perr_in;
      if (flash_start)
        cnt <= DONE_DLY;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// File: test_flash_self_programming_control.sv
// self-checking bench for the flash self-programming control block
// assumes fsp_ctrl and the flash model; one 125 MHz clock
`timescale 1ns/10ps
module test_flash_self_programming_control;
  logic clk, rst_n, reg_wr, reg_rd, cpu_halt, wake_req, verr, perr;
  logic [15:0] reg_addr, flash_addr;
  logic [7:0] reg_wdata, reg_rdata, flash_wr_buf, flash_rdata, flash_wdata;
  logic cpu_stall, halt_release, standby, irq_enable, pin_hold, ram_block;
  logic sec_override, flash_start, flash_done, flash_verify_err, flash_protect_err, flash_rd;
  logic [2:0] flash_cmd;
  int fail_count, checks, n;

  fsp_ctrl uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_halt, .wake_req, .cpu_stall, .halt_release, .standby, .irq_enable, .pin_hold,
    .ram_block, .sec_override, .flash_start, .flash_cmd, .flash_wdata, .flash_wr_buf,
    .flash_done, .flash_verify_err, .flash_protect_err, .flash_rd, .flash_addr, .flash_rdata);
  fsp_flash_model flash (.clk, .rst_n, .flash_rd, .flash_addr, .flash_start, .verr_in(verr),
    .perr_in(perr), .flash_rdata, .flash_done, .flash_verify_err, .flash_protect_err);

  // 125 MHz, far above the 1 MHz floor for self-programming
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  // byte-wide stores only, one strobe cycle each
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp));
  end
  endtask

  task automatic unlock(input logic [7:0] v, input logic [7:0] inv);
  begin
    wr(16'hffa0, 8'ha5);
    wr(16'hffa2, v);
    wr(16'hffa2, inv);
    wr(16'hffa2, v);
  end
  endtask

  // returns one step after the edge that takes the halt
  task automatic halt;
  begin
    @(posedge clk);
    cpu_halt <= 1'b1;
    @(posedge clk);
    cpu_halt <= 1'b0;
    #1;
  end
  endtask

  task automatic wait_rel;
  begin
    n = 0;
    while (halt_release !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  end
  endtask

  // interrupts masked and disabled in the cpu beforehand; nothing to drive here
  task automatic enter;
  begin
    wr(16'hffa3, 8'h00);
    unlock(8'h01, 8'hfe);
    halt;
    chk(cpu_stall, 1'b1);
    wait_rel;
    // 10 us at 8 ns plus two clocks: released on the 1252nd edge after the halt
    chk(16'(n), 16'd1252);
    repeat (1000) @(posedge clk);
  end
  endtask

  // watchdog and high pointer bits are cleared by software before this
  task automatic run_cmd(input logic [2:0] code, input logic v, input logic p,
    input logic [7:0] wd);
  begin
    wr(16'hffa3, {5'h00, code});
    verr <= v;
    perr <= p;
    halt;
    chk(flash_start, 1'b1);
    chk(cpu_stall, 1'b1);
    chk(ram_block, 1'b1);
    chk(16'(flash_cmd), 16'(code));
    chk(16'(flash_wdata), 16'(wd));
    wait_rel;
    // launch edge, model delay of 20, done edge, release edge: an early release trips this
    chk(16'(n), 16'd22);
    chk(cpu_stall, 1'b0);
    chk(ram_block, 1'b0);
  end
  endtask

  task automatic final_report;
  begin
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  initial
  begin
    #200000;
    fail_count++;
    final_report;
  end

  initial
  begin
    {rst_n, reg_wr, reg_rd, cpu_halt, wake_req, verr, perr} = '0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    flash_wr_buf = 8'h3c;
    fail_count = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    chk(irq_enable, 1'b0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(16'hffa2, 8'h54);
    rdc(16'hffa1, 8'h00);
    rdc(16'hff10, 8'h00);
    // stray store to the mode register, then a wrong inverse
    wr(16'hffa2, 8'hff);
    rdc(16'hffa2, 8'h54);
    rdc(16'hffa1, 8'h01);
    wr(16'hffa1, 8'h00);
    rdc(16'hffa1, 8'h00);
    unlock(8'h01, 8'h00);
    rdc(16'hffa2, 8'h54);
    rdc(16'hffa1, 8'h01);
    wr(16'hffa1, 8'h00);
    // normal mode: halt is plain standby until woken
    halt;
    chk(standby, 1'b1);
    chk(cpu_stall, 1'b0);
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    #1;
    chk(halt_release, 1'b1);
    chk(standby, 1'b0);
    enter;
    rdc(16'hffa2, 8'h55);
    chk(irq_enable, 1'b0);
    chk(pin_hold, 1'b1);
    chk(sec_override, 1'b1);
    run_cmd(3'h3, 1'b1, 1'b0, 8'hff);
    rdc(16'hffa1, 8'h02);
    wr(16'hffa1, 8'h00);
    run_cmd(3'h5, 1'b0, 1'b1, 8'h3c);
    rdc(16'hffa1, 8'h04);
    wr(16'hffa1, 8'h00);
    // empty command: released at once without a stall
    wr(16'hffa3, 8'h00);
    halt;
    chk(halt_release, 1'b1);
    chk(cpu_stall, 1'b0);
    unlock(8'h00, 8'hff);
    rdc(16'hffa2, 8'h54);
    chk(irq_enable, 1'b1);
    chk(pin_hold, 1'b0);
    chk(sec_override, 1'b0);
    // reset in mid-erase must drop the command and the mode
    enter;
    wr(16'hffa3, 8'h03);
    halt;
    chk(ram_block, 1'b1);
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(cpu_stall, 1'b0);
    chk(pin_hold, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(16'hffa2, 8'h54);
    final_report;
  end
endmodule
